/* File: verilog/fesc_map.vh */
// register map, command bytes and timing counts for the flash suspend controller
`ifndef FESC_MAP_VH
`define FESC_MAP_VH
// controller registers (byte addresses of own choosing)
`define FESC_REG_CTRL      4'h0
`define FESC_REG_ADDR      4'h4
`define FESC_REG_DATA      4'h8
`define FESC_REG_STATUS    4'hc
// control register fields
`define FESC_CTRL_GO       0
`define FESC_CTRL_OP_LSB   1
`define FESC_CTRL_OP_MSB   3
// operation codes written into the control register
`define FESC_OP_SUSPEND    3'h0
`define FESC_OP_RESUME     3'h1
`define FESC_OP_READ       3'h2
`define FESC_OP_ERASE      3'h3
`define FESC_OP_STATUS     3'h4
`define FESC_OP_SETUP      3'h5
// device command bytes
`define FESC_CMD_SUSPEND   8'hb0
`define FESC_CMD_RESUME    8'hd0
`define FESC_CMD_READ      8'hff
`define FESC_CMD_ERASE     8'h20
`define FESC_CMD_CONFIRM   8'hd0
`define FESC_CMD_STATUS    8'h70
// address bit where the block index starts; reads in a suspended block are refused until a resume or status operation
`define FESC_BLK_LSB       12
// device status bit positions
`define FESC_SR_READY      7
`define FESC_SR_SUSP       6
`define FESC_SR_ERASE_ERR  5
`define FESC_SR_PROG_ERR   4
// timing: recovery after reset/power-down release and the clock period, in ns
`define FESC_T_RECOVER_NS  480
`define FESC_CLK_NS        50
// bus phase length in cycles (strobe low time and high time)
`define FESC_PHASE_CYC     2
// status polls before giving up
`define FESC_POLL_MAX      16'hffff
`endif

/* File: verilog/fesc_ctrl.v */
// host-side controller sequencing erase, suspend, resume and reads on a parallel flash bus
// How it works
// - suspend writes b0 to pause erase
// - poll ready bit, toggling output enable
// - write ff, read other blocks only until a resume or status operation
// - resume writes d0 to restart erase
// - wait 480 ns after reset release
// - erase is 20 then d0 in block
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "fesc_map.vh"
module fesc_ctrl #(
  parameter AW = 17
) (
  input  wire          clk_sys,
  input  wire          rst_b,
  input  wire [3:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  output reg  [AW-1:0] flash_addr,
  output reg  [7:0]    flash_dq_out,
  output reg           flash_dq_oe_b,
  input  wire [7:0]    flash_dq_in,
  output reg           flash_ce_b,
  output reg           flash_oe_b,
  output reg           flash_we_b,
  output reg           reset_powerdown_pin
);
  localparam RECOVER_CYC = (`FESC_T_RECOVER_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS;
  localparam [3:0] S_RECOVER = 4'h0;
  localparam [3:0] S_IDLE    = 4'h1;
  localparam [3:0] S_WR_LO   = 4'h2;
  localparam [3:0] S_WR_HI   = 4'h3;
  localparam [3:0] S_RD_LO   = 4'h4;
  localparam [3:0] S_RD_HI   = 4'h5;
  localparam [3:0] S_DONE    = 4'h6;

  // recovery counter; the flash needs time after its reset pin rises
  localparam [4:0] RECOVER_LD = RECOVER_CYC[4:0];
  // coarse blocks: safe side, may refuse a read that the device would allow
  localparam BLK_LSB = `FESC_BLK_LSB;

  // synchronised data bus from the pins
  reg  [7:0]    dq_meta;
  reg  [7:0]    dq_sync;

  reg  [3:0]    state;
  reg  [2:0]    op;
  reg  [1:0]    step;
  reg  [4:0]    wait_cnt;
  reg  [AW-1:0] addr_reg;
  reg  [7:0]    rd_data;
  reg  [7:0]    dev_status;
  reg  [15:0]   poll_cnt;
  reg           busy;
  reg           timeout;
  reg           resp_susp;
  reg           rst_req;
  reg           blk_refused;
  reg  [AW-1:0] erase_addr;

  // byte that a given operation writes at a given step
  function [7:0] cmd_byte;
    input [2:0] o;
    input [1:0] s;
    begin
      case (o)
        `FESC_OP_SUSPEND: cmd_byte = `FESC_CMD_SUSPEND;
        `FESC_OP_RESUME:  cmd_byte = `FESC_CMD_RESUME;
        `FESC_OP_ERASE:   cmd_byte = (s == 2'd0) ? `FESC_CMD_ERASE : `FESC_CMD_CONFIRM;
        `FESC_OP_STATUS:  cmd_byte = `FESC_CMD_STATUS;
        `FESC_OP_SETUP:   cmd_byte = `FESC_CMD_ERASE;
        default:          cmd_byte = `FESC_CMD_READ;
      endcase
    end
  endfunction

  // block index of an address
  function [AW-1:0] blk_idx;
    input [AW-1:0] a;
    begin
      blk_idx = a >> BLK_LSB;
    end
  endfunction

  // last cycle of a strobe phase
  function phase_end;
    input [4:0] c;
    begin
      phase_end = (c == `FESC_PHASE_CYC - 1);
    end
  endfunction

  wire          go_wr  = reg_wr && (reg_addr == `FESC_REG_CTRL) && reg_wdata[`FESC_CTRL_GO];
  wire [2:0]    go_op  = reg_wdata[`FESC_CTRL_OP_MSB:`FESC_CTRL_OP_LSB];

  // a read inside the suspended block would see status, not array data
  wire          refuse = (go_op == `FESC_OP_READ) && resp_susp &&
                         (blk_idx(addr_reg) == blk_idx(erase_addr));

  always @(posedge clk_sys) begin
    dq_meta <= flash_dq_in;
    dq_sync <= dq_meta;
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state               <= S_RECOVER;
      op                  <= 3'h0;
      step                <= 2'd0;
      wait_cnt            <= RECOVER_LD;
      addr_reg            <= {AW{1'b0}};
      rd_data             <= 8'h00;
      dev_status          <= 8'h00;
      poll_cnt            <= 16'h0000;
      busy                <= 1'b1;
      timeout             <= 1'b0;
      resp_susp           <= 1'b0;
      rst_req             <= 1'b0;
      blk_refused         <= 1'b0;
      erase_addr          <= {AW{1'b0}};
      flash_addr          <= {AW{1'b0}};
      flash_dq_out        <= 8'h00;
      flash_dq_oe_b       <= 1'b1;
      flash_ce_b          <= 1'b1;
      flash_oe_b          <= 1'b1;
      flash_we_b          <= 1'b1;
      reset_powerdown_pin <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `FESC_REG_ADDR)
        addr_reg <= reg_wdata[AW-1:0];
      case (state)
        S_RECOVER: begin
          reset_powerdown_pin <= 1'b1;
          // no chip-enable access until the recovery time has passed
          if (wait_cnt == 5'd0) begin
            state <= S_IDLE;
            busy  <= 1'b0;
          end else begin
            wait_cnt <= wait_cnt - 5'd1;
          end
        end

        S_IDLE: begin
          // a pending pin reset goes first so no access starts with the pin low
          if (rst_req) begin
            rst_req  <= 1'b0;
            busy     <= 1'b1;
            wait_cnt <= RECOVER_LD;
            state    <= S_RECOVER;
          end else if (go_wr) begin
            op          <= go_op;
            step        <= 2'd0;
            busy        <= 1'b1;
            timeout     <= 1'b0;
            blk_refused <= refuse;
            poll_cnt    <= 16'h0000;
            flash_addr  <= (go_op == `FESC_OP_STATUS) ? flash_addr : addr_reg;
            if (go_op == `FESC_OP_ERASE)
              erase_addr <= addr_reg;
            if (refuse)
              state <= S_DONE;
            else
              state <= S_WR_LO;
            wait_cnt    <= 5'd0;
          end else if (reg_wr && reg_addr == `FESC_REG_STATUS && reg_wdata[0]) begin
            // software pulse of the flash reset pin, then recovery again
            reset_powerdown_pin <= 1'b0;
            busy                <= 1'b1;
            rst_req             <= 1'b1;
          end
        end

        S_WR_LO: begin
          flash_dq_out  <= cmd_byte(op, step);
          flash_dq_oe_b <= 1'b0;
          flash_ce_b    <= 1'b0;
          flash_we_b    <= 1'b0;
          if (phase_end(wait_cnt)) begin
            wait_cnt <= 5'd0;
            state    <= S_WR_HI;
          end else begin
            wait_cnt <= wait_cnt + 5'd1;
          end
        end

        S_WR_HI: begin
          // strobe rises first; data held one more phase for hold time
          flash_we_b <= 1'b1;
          flash_ce_b <= 1'b1;
          if (phase_end(wait_cnt)) begin
            wait_cnt      <= 5'd0;
            flash_dq_oe_b <= 1'b1;
            if (op == `FESC_OP_ERASE && step == 2'd0) begin
              step  <= 2'd1;
              state <= S_WR_LO;
            end else if (op == `FESC_OP_ERASE || op == `FESC_OP_SETUP) begin
              // erase runs on in the device, so a suspend can be issued meanwhile
              state <= S_DONE;
            end else if (op == `FESC_OP_READ) begin
              state <= S_RD_LO;
            end else if (op == `FESC_OP_RESUME) begin
              resp_susp <= 1'b0;
              state     <= S_DONE;
            end else begin
              state <= S_RD_LO;
            end
          end else begin
            wait_cnt <= wait_cnt + 5'd1;
          end
        end

        S_RD_LO: begin
          flash_ce_b <= 1'b0;
          flash_oe_b <= 1'b0;
          // one phase plus two synchroniser stages before sampling
          if (wait_cnt == `FESC_PHASE_CYC + 2) begin
            wait_cnt <= 5'd0;
            rd_data  <= dq_sync;
            state    <= S_RD_HI;
          end else begin
            wait_cnt <= wait_cnt + 5'd1;
          end
        end

        S_RD_HI: begin
          // deassert output enable between polls so status refreshes
          flash_oe_b <= 1'b1;
          flash_ce_b <= 1'b1;
          if (phase_end(wait_cnt)) begin
            wait_cnt <= 5'd0;
            if (op == `FESC_OP_READ) begin
              state <= S_DONE;
            end else begin
              dev_status <= rd_data;
              if (rd_data[`FESC_SR_READY]) begin
                // a suspend that found no erase running leaves this clear
                resp_susp <= (op == `FESC_OP_SUSPEND) & rd_data[`FESC_SR_SUSP];
                state     <= S_DONE;
              end else if (poll_cnt == `FESC_POLL_MAX) begin
                timeout <= 1'b1;
                state   <= S_DONE;
              end else begin
                poll_cnt <= poll_cnt + 16'h0001;
                state    <= S_RD_LO;
              end
            end
          end else begin
            wait_cnt <= wait_cnt + 5'd1;
          end
        end

        S_DONE: begin
          busy  <= 1'b0;
          state <= S_IDLE;
        end

        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin

      if (reg_addr == `FESC_REG_CTRL) begin
        reg_rdata <= {28'h0000000, op, busy};
      end else if (reg_addr == `FESC_REG_ADDR) begin
        reg_rdata <= {{(32-AW){1'b0}}, addr_reg};
      end else if (reg_addr == `FESC_REG_DATA) begin
        reg_rdata <= {24'h000000, rd_data};
      end else if (reg_addr == `FESC_REG_STATUS) begin
        // both error bits together mean a bad erase sequence
        reg_rdata <= {19'h00000, blk_refused, timeout, resp_susp,
                      dev_status[`FESC_SR_ERASE_ERR] & dev_status[`FESC_SR_PROG_ERR],
                      1'b0, dev_status};
      end else begin
        reg_rdata <= 32'h00000000;
      end

    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

/* File: verification/fesc_flash_model.sv */
// behavioural boot-block flash device on the far side of the controller
`timescale 1ns/10ps
module fesc_flash_model #(
  parameter ERASE_NS = 2000,
  parameter PROG_NS  = 15000
) (
  input  wire [16:0] addr,
  input  wire [7:0]  din,
  input  wire        ce_b,
  input  wire        oe_b,
  input  wire        we_b,
  input  wire        pd_b,
  output wire [7:0]  dout
);
  reg  [7:0] sr;
  reg  [7:0] hold = 8'h00;
  reg        rd_arr, setup, prog, busy, susp;
  reg        rec_err = 1'b0;
  integer    left;
  realtime   t_rel = 0;
  wire       drv = !ce_b && !oe_b && pd_b;
  wire       wr = !we_b && !ce_b && pd_b;
  wire [7:0] val = rd_arr ? (addr[7:0] ^ 8'h5a) : sr;
  // released bus shows the inverse of its last value, never a stale copy
  assign dout = drv ? val : ~hold;
  always @* if (drv) hold = val;
  // no unlock level is ever applied here, so the boot block never leaves its lock
  always @(negedge pd_b) begin
    sr = 8'h80; rd_arr = 1; setup = 0; prog = 0; busy = 0; susp = 0; left = 0;
  end
  always @(posedge pd_b) t_rel = $realtime;
  always @(negedge ce_b) if (pd_b && $realtime - t_rel < 480) rec_err = 1;
  always @(negedge wr) begin
    rd_arr = (din == 8'hff);
    if (setup) begin
      setup = 0;
      if (din == 8'hd0) begin busy = 1; left = ERASE_NS; sr = 8'h00; end
      else sr = 8'hb0;
    end else if (prog) begin prog = 0; busy = 1; left = PROG_NS; sr = 8'h00; end
    else if (din == 8'h20) setup = 1;
    else if (din == 8'h40) prog = 1;
    else if (din == 8'hb0 && busy) begin busy = 0; susp = 1; sr = 8'hc0; end
    else if (din == 8'hd0 && susp) begin busy = 1; susp = 0; sr = 8'h00; end
  end
  always #50 if (busy) begin
    left = left - 50;
    if (left <= 0) begin busy = 0; sr = 8'h80; end
  end
endmodule

/* File: verification/fesc_ctrl_chk.sv */
// port assertions for the flash suspend controller
`timescale 1ns/10ps
module fesc_ctrl_chk #(
  parameter AW = 17
) (
  input wire          clk_sys,
  input wire          rst_b,
  input wire          reg_rd,
  input wire [31:0]   reg_rdata,
  input wire [AW-1:0] flash_addr,
  input wire [7:0]    flash_dq_out,
  input wire          flash_dq_oe_b,
  input wire          flash_ce_b,
  input wire          flash_oe_b,
  input wire          flash_we_b,
  input wire          reset_powerdown_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // saturating count of cycles since the reset pin went high
  reg [3:0] rec;
  always @(posedge clk_sys) if (!reset_powerdown_pin) rec <= 4'h0;
    else if (rec != 4'hf) rec <= rec + 4'h1;
  a_recover_gap: assert property (!flash_ce_b |-> rec >= 4'ha)
    else $error("chip enable too soon after reset pin release");
  a_strobe_excl: assert property (!(!flash_we_b && !flash_oe_b))
    else $error("write and output enable low together");
  a_write_drive: assert property (!flash_we_b |-> !flash_dq_oe_b && !flash_ce_b)
    else $error("write strobe without data drive or chip enable");
  a_read_float: assert property (!flash_oe_b |-> flash_dq_oe_b)
    else $error("controller drives data during a read");
  a_we_width: assert property ($fell(flash_we_b) |=> !flash_we_b ##1 flash_we_b)
    else $error("write strobe not two cycles low");
  a_cmd_stable: assert property (!flash_we_b && $past(!flash_we_b) |->
    $stable(flash_dq_out) && $stable(flash_addr))
    else $error("command byte or address moved in a write");
  a_oe_toggle: assert property ($fell(flash_oe_b) |-> !flash_oe_b[*5] ##1 flash_oe_b)
    else $error("output enable not five cycles low then high");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind fesc_ctrl fesc_ctrl_chk #(.AW(AW)) fesc_ctrl_chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_b(flash_dq_oe_b), .flash_ce_b(flash_ce_b),
  .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .reset_powerdown_pin(reset_powerdown_pin));

/* File: verification/testbench.sv */
// self-checking bench for the flash suspend controller
`timescale 1ns/10ps
`include "fesc_map.vh"
module testbench;
  reg         clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0, rd_val;
  wire [31:0] reg_rdata;
  wire [16:0] f_addr;
  wire [7:0]  f_out, f_dev, dq;
  wire        f_dq_oe_b, ce_b, oe_b, we_b, f_pd_b;
  integer     mismatches = 0, num_checks = 0;
  realtime    t0;
  always #25 clk_sys = ~clk_sys;
  assign dq = !f_dq_oe_b ? f_out : f_dev;
  fesc_ctrl fesc_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(f_addr), .flash_dq_out(f_out), .flash_dq_oe_b(f_dq_oe_b), .flash_dq_in(dq),
    .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_we_b(we_b), .reset_powerdown_pin(f_pd_b));
  fesc_flash_model fesc_flash_model_i (.addr(f_addr), .din(dq), .ce_b(ce_b), .oe_b(oe_b),
    .we_b(we_b), .pd_b(f_pd_b), .dout(f_dev));
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
      @(posedge clk_sys);
      reg_wr <= 0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      reg_addr <= a; reg_rd <= 1;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 rd_val = reg_rdata;
      @(posedge clk_sys);
    end
  endtask
  // bounded wait; a hung sequencer shows as a failed check, not a hang
  task wait_idle;
    integer n;
    begin
      n = 0;
      rd(`FESC_REG_CTRL);
      while (rd_val[0] !== 1'b0 && n < 3000) begin rd(`FESC_REG_CTRL); n = n + 1; end
      check(n < 3000, 1);
    end
  endtask
  task go(input [2:0] op);
    begin
      wr(`FESC_REG_CTRL, {28'h0, op, 1'b1});
      rd(`FESC_REG_CTRL);
      check(rd_val[3:0], {op, 1'b1});
      wait_idle;
    end
  endtask
  // address write followed by a read-back, so two writes never abut
  task set_addr(input [31:0] a);
    begin
      wr(`FESC_REG_ADDR, a);
      rd(`FESC_REG_ADDR);
      check(rd_val, a);
    end
  endtask
  task s_erase;
    begin
      set_addr(32'h1000);
      t0 = $realtime;
      go(`FESC_OP_ERASE);
      go(`FESC_OP_STATUS);
      check($realtime - t0 >= 2000, 1);
      rd(`FESC_REG_STATUS);
      check(rd_val[10:0], 11'h080);
    end
  endtask
  task s_suspend_resume;
    begin
      go(`FESC_OP_SUSPEND);
      rd(`FESC_REG_STATUS);
      check(rd_val[10:0], 11'h080);
      set_addr(32'h1000);
      go(`FESC_OP_ERASE);
      go(`FESC_OP_SUSPEND);
      rd(`FESC_REG_STATUS);
      check(rd_val[10:0], 11'h4c0);
      set_addr(32'h1234);
      go(`FESC_OP_READ);
      rd(`FESC_REG_STATUS);
      check(rd_val[12], 1);
      set_addr(32'h0123);
      go(`FESC_OP_READ);
      rd(`FESC_REG_STATUS);
      check(rd_val[12], 0);
      rd(`FESC_REG_DATA);
      check(rd_val[7:0], 8'h79);
      go(`FESC_OP_RESUME);
      rd(`FESC_REG_STATUS);
      check(rd_val[10], 0);
      go(`FESC_OP_STATUS);
      rd(`FESC_REG_STATUS);
      check(rd_val[7:0], 8'h80);
      rd(4'h2);
      check(rd_val, 0);
    end
  endtask
  task s_seq_err;
    begin
      go(`FESC_OP_SETUP);
      go(`FESC_OP_READ);
      go(`FESC_OP_STATUS);
      rd(`FESC_REG_STATUS);
      check(rd_val[9], 1);
      check(rd_val[7:0], 8'hb0);
    end
  endtask
  task s_pin_reset;
    begin
      wr(`FESC_REG_STATUS, 32'h1);
      wait_idle;
      go(`FESC_OP_STATUS);
      rd(`FESC_REG_STATUS);
      check(rd_val[7:0], 8'h80);
      check(fesc_flash_model_i.rec_err, 0);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    mismatches = mismatches + 1;
    test_done;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    wait_idle;
    check(f_pd_b, 1);
    s_erase;
    s_suspend_resume;
    s_seq_err;
    s_pin_reset;
    test_done;
  end
endmodule
